//--- ccg_pkg.sv
// Shared constants, register map and carrier types of the camera capture block
package ccg_pkg;

  // ---------------------------------------------------------------
  // Clock rates and derived cycle counts
  // ---------------------------------------------------------------
  localparam int unsigned REF_CLK_HZ = 40_000_000;      // ref_clk rate
  localparam int unsigned MCLK_TARGET_HZ = 24_000_000;  // Wanted camera master clock
  localparam int unsigned PIX_CLK_MIN_HZ = 100_000;     // Slowest legal pixel clock
  localparam int unsigned PIX_CLK_MAX_HZ = 16_000_000;  // Fastest legal pixel clock
  // Half period of the master clock in ref cycles, never below one cycle
  localparam int unsigned MCLK_HALF_CYC =
    ((REF_CLK_HZ / (2 * MCLK_TARGET_HZ)) == 0) ? 1 : (REF_CLK_HZ / (2 * MCLK_TARGET_HZ));
  localparam logic [3:0] MCLK_HALF_LAST = 4'(MCLK_HALF_CYC - 1);

  // ---------------------------------------------------------------
  // Graphics memory geometry (word indices)
  // ---------------------------------------------------------------
  localparam int unsigned MEM_BYTES = 163840;          // 160 kB
  localparam int unsigned MEM_WORDS = MEM_BYTES / 4;   // 40960 words
  localparam logic [15:0] AREA0_FIRST = 16'h0000;      // User-interface graphics
  localparam logic [15:0] AREA0_LAST = 16'h3FFF;
  localparam logic [15:0] AREA1_FIRST = 16'h4000;      // Still / video / camera frame A
  localparam logic [15:0] AREA1_LAST = 16'h6FFF;
  localparam logic [15:0] AREA2_FIRST = 16'h7000;      // Still / video / camera frame B
  localparam logic [15:0] AREA2_LAST = 16'h9FFF;
  localparam logic [15:0] MEM_LAST = 16'h9FFF;         // Combined frame buffer end

  // ---------------------------------------------------------------
  // Register map (byte addresses on the bus)
  // ---------------------------------------------------------------
  localparam logic [19:0] CTRL_OFS = 20'h00000;
  localparam logic [19:0] STATUS_OFS = 20'h00004;
  localparam logic [19:0] MASK_OFS = 20'h00008;
  localparam logic [19:0] CLKRST_OFS = 20'h0000C;
  localparam logic [19:0] LINES_OFS = 20'h00010;
  localparam logic [19:0] WRPTR_OFS = 20'h00014;
  localparam logic [1:0] MEM_REGION = 2'h1;            // adr[19:18] of the memory window

  // Event bit positions in the status register
  localparam int EV_FRAME_START = 0;
  localparam int EV_FRAME_END = 1;
  localparam int EV_TRUNC = 2;
  localparam int EV_OVERFLOW = 3;
  localparam int EV_W = 4;

  // Submodule index in clock enable and reset vectors
  localparam int SUB_ENGINE = 0;
  localparam int SUB_MEMORY = 1;
  localparam int SUB_DISPLAY = 2;
  localparam int SUB_CAPTURE = 3;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] skipN;          // Frames skipped after each captured frame
    logic [1:0] areaSel;        // 0 UI, 1 area A, 2 area B, 3 whole memory
    logic [1:0] yuvOrder;       // Component reorder mode
    logic fmtYuv;               // Stream holds YUV data
    logic dispAuto;             // Forward words to the display path
    logic dmaRoute;             // Words go to DMA instead of memory
    logic frameSyncHigh;        // Frame sync active level
    logic lineSyncHigh;         // Line sync active level
    logic capEn;                // Capture enable
  } ccg_ctrl_s;

  typedef struct packed {
    logic camPowerOn;           // Camera power-on control
    logic dispRstRelease;       // Release display reset
    logic camRstRelease;        // Release camera reset
    logic [3:0] softRst;        // Hold a submodule in reset
    logic [3:0] clkEn;          // Per-submodule clock enable
  } ccg_clkrst_s;

  // Values after reset
  localparam ccg_ctrl_s CTRL_RST = 14'h0006;
  localparam ccg_clkrst_s CLKRST_RST = 11'h00F;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;

endpackage : ccg_pkg

//--- ccg_capture_top.sv
// Camera capture port, graphics memory and subsystem clock/reset control
// Function
// - Take one byte per pixel clock rising edge
// - Pixel clock from 100 kHz to 16 MHz
// - Line sync delimits lines, polarity selectable
// - Frame sync delimits frames, polarity selectable
// - Skip selected frames to lower frame rate
// - Interrupts report image progress and errors
// - YUV 4:2:2 input, programmable component reorder
// - Detect image end, truncate, flag overflow
// - Any format captured; only YUV to display
// - Captured words may go to DMA instead
// - 160 kB memory, byte/half/word access
// - Write one cycle; reads two, sequential one
// - Three image areas, combinable into one
// - VGA frame into memory within 50 ms
// - Gate and distribute bus clock per submodule
// - Fan out resets; camera/display reset outputs
// - Master clock to camera; pixel stream back
// - Camera power-on low during reset
`timescale 1ns/1ps

module ccg_capture_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [19:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire logic cameraPixelClockIn,
  input wire logic frameSync,
  input wire logic lineSync,
  input wire logic [7:0] cameraPixelBus,
  output logic cameraMasterClock,
  output logic cameraResetOut_n,
  output logic displayResetOut_n,
  output logic cameraPowerOn,
  output logic [3:0] subClkEn,
  output logic [3:0] subReset_n,
  output logic dmaValid,
  output logic [31:0] dmaData,
  input wire logic dmaReady,
  output logic dispValid,
  output logic [31:0] dispData,
  output logic irq
);

  // ---------------------------------------------------------------
  // Software-visible registers
  // ---------------------------------------------------------------
  ccg_pkg::ccg_ctrl_s ctrl_reg;          // Capture configuration
  ccg_pkg::ccg_clkrst_s clkRst_reg;      // Clock gating and reset control
  logic [ccg_pkg::EV_W-1:0] status_reg;  // Sticky events
  logic [ccg_pkg::EV_W-1:0] status_next;
  logic [ccg_pkg::EV_W-1:0] mask_reg;    // Interrupt mask
  logic [15:0] lineLatch_reg;            // Lines seen in the last kept frame
  logic [3:0] subRst_reg;                // Registered submodule resets

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic pclkS1, pclkS2, pclkS3;          // Pixel clock, stage 3 feeds the edge detector
  logic fsS1, fsS2;                      // Frame sync
  logic lsS1, lsS2;                      // Line sync
  logic [7:0] busS1, busS2;              // Pixel bus, same latency as the clock

  // All pins pass two flops; data and clock share that latency so they stay aligned
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {pclkS1, pclkS2, pclkS3} <= 3'h0;
      {fsS1, fsS2, lsS1, lsS2} <= 4'h0;
      busS1 <= 8'h00;
      busS2 <= 8'h00;
    end else begin
      {pclkS1, pclkS2, pclkS3} <= {cameraPixelClockIn, pclkS1, pclkS2};
      {fsS1, fsS2, lsS1, lsS2} <= {frameSync, fsS1, lineSync, lsS1};
      busS1 <= cameraPixelBus;
      busS2 <= busS1;
    end
  end

  // 40 MHz sampling sees a 16 MHz pixel clock only if each phase lasts one ref period
  wire pixEdge = pclkS2 & ~pclkS3;
  wire frameAct = ctrl_reg.frameSyncHigh ? fsS2 : ~fsS2;
  wire lineAct = ctrl_reg.lineSyncHigh ? lsS2 : ~lsS2;

  // ---------------------------------------------------------------
  // Clock gating and reset distribution
  // ---------------------------------------------------------------
  wire capRun = ctrl_reg.capEn & clkRst_reg.clkEn[ccg_pkg::SUB_CAPTURE]
    & subRst_reg[ccg_pkg::SUB_CAPTURE];
  wire memOn = clkRst_reg.clkEn[ccg_pkg::SUB_MEMORY] & subRst_reg[ccg_pkg::SUB_MEMORY];

  // Resets are registered so every submodule leaves reset on the same edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      subRst_reg <= 4'h0;
    end else begin
      subRst_reg <= ~clkRst_reg.softRst;
    end
  end

  assign subClkEn = clkRst_reg.clkEn;
  assign subReset_n = subRst_reg;
  assign cameraResetOut_n = clkRst_reg.camRstRelease;
  assign displayResetOut_n = clkRst_reg.dispRstRelease;
  // Flop resets to zero, so the pin is low throughout reset
  assign cameraPowerOn = clkRst_reg.camPowerOn;

  // ---------------------------------------------------------------
  // Camera master clock divider
  // ---------------------------------------------------------------
  logic [3:0] mclkCnt_reg;
  logic mclk_reg;

  // An integer divider of ref_clk cannot reach 24 MHz; the fastest is half the rate
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mclkCnt_reg <= 4'h0;
      mclk_reg <= 1'b0;
    end else if (mclkCnt_reg == ccg_pkg::MCLK_HALF_LAST) begin
      mclkCnt_reg <= 4'h0;
      mclk_reg <= ~mclk_reg;
    end else begin
      mclkCnt_reg <= mclkCnt_reg + 4'h1;
    end
  end

  assign cameraMasterClock = mclk_reg;

  // ---------------------------------------------------------------
  // Frame and line tracking, frame skipping
  // ---------------------------------------------------------------
  logic frameAct_reg, lineAct_reg;
  logic capFrame_reg;                    // Current frame is being kept
  logic [3:0] skipCnt_reg;
  logic [15:0] lineCnt_reg;

  wire frameRise = frameAct & ~frameAct_reg;
  wire frameFall = ~frameAct & frameAct_reg;
  wire lineFall = ~lineAct & lineAct_reg;
  wire keepFrame = frameRise & capRun & (skipCnt_reg == 4'h0);

  // Skip counter reloads on each kept frame, so one of every skipN+1 frames is kept
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frameAct_reg <= 1'b0;
      lineAct_reg <= 1'b0;
      capFrame_reg <= 1'b0;
      skipCnt_reg <= 4'h0;
    end else begin
      frameAct_reg <= frameAct;
      lineAct_reg <= lineAct;
      if (frameRise && capRun) begin
        capFrame_reg <= keepFrame;
        skipCnt_reg <= keepFrame ? ctrl_reg.skipN : skipCnt_reg - 4'h1;
      end else if (frameFall || !capRun) begin
        capFrame_reg <= 1'b0;
      end
    end
  end

  // Count lines of kept frames; latch the total at the end of the image
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lineCnt_reg <= 16'h0000;
      lineLatch_reg <= 16'h0000;
    end else if (frameRise) begin
      lineCnt_reg <= 16'h0000;
    end else if (frameFall && capFrame_reg) begin
      lineLatch_reg <= lineCnt_reg;
    end else if (lineFall && capFrame_reg) begin
      lineCnt_reg <= lineCnt_reg + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Byte packing and component reorder
  // ---------------------------------------------------------------
  logic [23:0] shift_reg;
  logic [1:0] byteIdx_reg;

  // Bytes count only inside an active line of an active, kept frame
  wire byteStrobe = pixEdge & capFrame_reg & frameAct & lineAct;
  wire wordDone = byteStrobe & (byteIdx_reg == 2'h3);
  wire [31:0] rawWord = {shift_reg, busS2};

  // Format does not matter here: JPEG or RGB packs the same way
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= 24'h000000;
      byteIdx_reg <= 2'h0;
    end else if (frameRise) begin
      byteIdx_reg <= 2'h0;
    end else if (byteStrobe) begin
      shift_reg <= rawWord[23:0];
      byteIdx_reg <= byteIdx_reg + 2'h1;
    end
  end

  // Byte 3 is the first received; modes swap pairs, chroma or luma positions
  wire [31:0] wordSwapPairs = {rawWord[23:16], rawWord[31:24], rawWord[7:0], rawWord[15:8]};
  wire [31:0] wordSwapChroma = {rawWord[15:8], rawWord[23:16], rawWord[31:24], rawWord[7:0]};
  wire [31:0] wordSwapLuma = {rawWord[31:24], rawWord[7:0], rawWord[15:8], rawWord[23:16]};
  wire [31:0] capWord = (ctrl_reg.yuvOrder == 2'h0) ? rawWord :
                        (ctrl_reg.yuvOrder == 2'h1) ? wordSwapPairs :
                        (ctrl_reg.yuvOrder == 2'h2) ? wordSwapChroma :
                        wordSwapLuma;

  // ---------------------------------------------------------------
  // Word FIFO between capture and memory or DMA
  // ---------------------------------------------------------------
  logic [31:0] fifoMem [4];
  logic [2:0] fifoWr_reg, fifoRd_reg;

  wire fifoEmpty = (fifoWr_reg == fifoRd_reg);
  wire fifoFull = (fifoWr_reg[1:0] == fifoRd_reg[1:0]) & (fifoWr_reg[2] != fifoRd_reg[2]);
  wire fifoPush = wordDone & ~fifoFull;
  wire overflowEv = wordDone & fifoFull;
  wire [31:0] fifoHead = fifoMem[fifoRd_reg[1:0]];

  // Memory drain yields to bus writes, so a busy bus backs words up into the FIFO
  logic busMemWr;
  wire popMem = ~ctrl_reg.dmaRoute & ~fifoEmpty & memOn & ~busMemWr;
  wire popDma = ctrl_reg.dmaRoute & ~fifoEmpty & dmaReady;
  wire fifoPop = popMem | popDma;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fifoWr_reg <= 3'h0;
      fifoRd_reg <= 3'h0;
    end else begin
      if (fifoPush) begin
        fifoWr_reg <= fifoWr_reg + 3'h1;
      end
      if (fifoPop) begin
        fifoRd_reg <= fifoRd_reg + 3'h1;
      end
    end
  end

  // Storage carries no reset; pointers alone define what is valid
  always_ff @(posedge ref_clk) begin
    if (fifoPush) begin
      fifoMem[fifoWr_reg[1:0]] <= capWord;
    end
  end

  assign dmaValid = ctrl_reg.dmaRoute & ~fifoEmpty;
  assign dmaData = fifoHead;

  // ---------------------------------------------------------------
  // Capture write pointer and image area selection
  // ---------------------------------------------------------------
  logic [15:0] capPtr_reg;

  wire [15:0] areaFirst = (ctrl_reg.areaSel == 2'h1) ? ccg_pkg::AREA1_FIRST :
                          (ctrl_reg.areaSel == 2'h2) ? ccg_pkg::AREA2_FIRST :
                          ccg_pkg::AREA0_FIRST;
  wire [15:0] areaLast = (ctrl_reg.areaSel == 2'h0) ? ccg_pkg::AREA0_LAST :
                         (ctrl_reg.areaSel == 2'h1) ? ccg_pkg::AREA1_LAST :
                         ccg_pkg::MEM_LAST;
  wire capInRange = (capPtr_reg <= areaLast);
  wire capWr = popMem & capInRange;
  wire truncEv = popMem & ~capInRange;

  // One word per ref cycle is far above the needed 3 Mword/s for VGA in 50 ms
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      capPtr_reg <= ccg_pkg::AREA0_FIRST;
    end else if (keepFrame) begin
      capPtr_reg <= areaFirst;
    end else if (capWr) begin
      capPtr_reg <= capPtr_reg + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Display forwarding
  // ---------------------------------------------------------------
  logic dispValid_reg;
  logic [31:0] dispData_reg;

  // Only YUV streams may reach the display; other formats go only to memory or DMA
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dispValid_reg <= 1'b0;
      dispData_reg <= 32'h00000000;
    end else begin
      dispValid_reg <= fifoPop & ctrl_reg.dispAuto & ctrl_reg.fmtYuv;
      if (fifoPop) begin
        dispData_reg <= fifoHead;
      end
    end
  end

  assign dispValid = dispValid_reg;
  assign dispData = dispData_reg;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic ack_reg;
  logic rdWait_reg;                      // First cycle of a two-cycle read done
  logic lastRdValid_reg;
  logic [15:0] lastRdIdx_reg;
  logic [31:0] dat_reg;

  wire access = cyc_i & stb_i & ~ack_reg;
  wire [15:0] memIdx = adr_i[17:2];
  wire memHit = (adr_i[19:18] == ccg_pkg::MEM_REGION) & (memIdx <= ccg_pkg::MEM_LAST);
  wire hitCtrl = (adr_i == ccg_pkg::CTRL_OFS);
  wire hitStatus = (adr_i == ccg_pkg::STATUS_OFS);
  wire hitMask = (adr_i == ccg_pkg::MASK_OFS);
  wire hitClkRst = (adr_i == ccg_pkg::CLKRST_OFS);
  wire hitLines = (adr_i == ccg_pkg::LINES_OFS);
  wire hitWrPtr = (adr_i == ccg_pkg::WRPTR_OFS);
  wire regWr = access & we_i;

  // Next word after the previous read counts as a sequential beat
  wire seqHit = lastRdValid_reg & (memIdx == lastRdIdx_reg + 16'h0001);
  wire needWait = access & ~we_i & memHit & ~seqHit & ~rdWait_reg;
  wire ackNext = access & ~needWait;
  assign busMemWr = access & we_i & memHit & memOn;

  // ---------------------------------------------------------------
  // Graphics memory, one array per byte lane
  // ---------------------------------------------------------------
  logic [31:0] memRdWord;

  for (genvar g = 0; g < 4; g++) begin : gLane
    logic [7:0] laneMem [ccg_pkg::MEM_WORDS];
    // Lane enables give byte, halfword and word writes
    always_ff @(posedge ref_clk) begin
      if (busMemWr && sel_i[g]) begin
        laneMem[memIdx] <= dat_i[g*8 +: 8];
      end else if (capWr) begin
        laneMem[capPtr_reg] <= fifoHead[g*8 +: 8];
      end
    end
    assign memRdWord[g*8 +: 8] = (memOn && sel_i[g]) ? laneMem[memIdx] : 8'h00;
  end

  wire [31:0] regRdWord = hitCtrl ? 32'(ctrl_reg) :
                          hitStatus ? 32'(status_reg) :
                          hitMask ? 32'(mask_reg) :
                          hitClkRst ? 32'(clkRst_reg) :
                          hitLines ? {16'h0000, lineLatch_reg} :
                          hitWrPtr ? {14'h0000, capPtr_reg, 2'h0} :
                          32'h00000000;
  wire [31:0] rdWord = memHit ? memRdWord : regRdWord;

  // ---------------------------------------------------------------
  // Bus answer
  // ---------------------------------------------------------------
  // Ack is a one-cycle pulse; unmapped addresses are acked and read as zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      rdWait_reg <= 1'b0;
      dat_reg <= 32'h00000000;
      lastRdValid_reg <= 1'b0;
      lastRdIdx_reg <= 16'h0000;
    end else begin
      ack_reg <= ackNext;
      rdWait_reg <= needWait;
      if (ackNext && !we_i) begin
        dat_reg <= rdWord;
      end
      if (ackNext) begin
        lastRdValid_reg <= ~we_i & memHit;
        lastRdIdx_reg <= memIdx;
      end
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  // Writes use byte lanes; only lanes that hold bits are decoded
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= ccg_pkg::CTRL_RST;
      clkRst_reg <= ccg_pkg::CLKRST_RST;
      mask_reg <= ccg_pkg::MASK_RST;
    end else if (regWr) begin
      if (hitCtrl && sel_i[0]) begin
        ctrl_reg[7:0] <= dat_i[7:0];
      end
      if (hitCtrl && sel_i[1]) begin
        ctrl_reg[13:8] <= dat_i[13:8];
      end
      if (hitClkRst && sel_i[0]) begin
        clkRst_reg[7:0] <= dat_i[7:0];
      end
      if (hitClkRst && sel_i[1]) begin
        clkRst_reg[10:8] <= dat_i[10:8];
      end
      if (hitMask && sel_i[0]) begin
        mask_reg <= dat_i[ccg_pkg::EV_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Event status and interrupt
  // ---------------------------------------------------------------
  wire [ccg_pkg::EV_W-1:0] evSet = {overflowEv, truncEv, frameFall & capFrame_reg, keepFrame};
  wire [ccg_pkg::EV_W-1:0] evClr =
    (regWr && hitStatus && sel_i[0]) ? dat_i[ccg_pkg::EV_W-1:0] : 4'h0;

  // Write one to clear; an event in the same cycle keeps its bit set
  always_comb begin
    status_next = (status_reg & ~evClr) | evSet;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= 4'h0;
    end else begin
      status_reg <= status_next;
    end
  end

  assign irq = |(status_reg & mask_reg);

endmodule : ccg_capture_top

//--- ccg_capture_assertions.sv
// Concurrent checks on the ports of the camera capture block
`timescale 1ns/1ps
module ccg_capture_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [19:0] adr_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic [31:0] dat_o,
  input wire logic cameraMasterClock,
  input wire logic cameraResetOut_n,
  input wire logic cameraPowerOn,
  input wire logic [3:0] subReset_n,
  input wire logic dmaValid,
  input wire logic [31:0] dmaData,
  input wire logic dmaReady
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic req = cyc_i && stb_i && !ack_o;  // Request not yet answered
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o) else $error("ack too long");
  AST_WR_ONE: assert property (req && we_i |=> ack_o) else $error("write ack late");
  AST_UNMAPPED: assert property (req && !we_i && adr_i[19:18] == 2'h3 |=>
    ack_o && dat_o == 32'h0000_0000) else $error("unmapped read");
  AST_MCLK: assert property ($past(rst_n) |->
    cameraMasterClock != $past(cameraMasterClock)) else $error("master clock stuck");
  AST_SUBRST: assert property ($rose(rst_n) |=> subReset_n == 4'hF) else $error("fan-out");
  AST_PWR_LOW: assert property ($rose(rst_n) |-> !cameraPowerOn && !cameraResetOut_n)
    else $error("camera not held");
  AST_RST_OUT: assert property ($rose(cameraResetOut_n) |->
    $past(we_i) || $past(we_i, 2)) else $error("reset out unasked");
  AST_DMA_HOLD: assert property (dmaValid && !dmaReady |=>
    dmaValid && $stable(dmaData)) else $error("dma word lost");
  // Main scenarios reached
  cover property (dmaValid && dmaReady);
  cover property (ack_o && !we_i);
  cover property ($rose(cameraResetOut_n));
endmodule : ccg_capture_chk
bind ccg_capture_top ccg_capture_chk ccg_capture_chk_i (.ref_clk, .rst_n, .adr_i, .we_i, .cyc_i,
  .stb_i, .ack_o, .dat_o, .cameraMasterClock, .cameraResetOut_n, .cameraPowerOn, .subReset_n,
  .dmaValid, .dmaData, .dmaReady);

//--- ccg_cam_model.sv
// Behavioural camera sensor on the pixel link
`timescale 1ns/1ps
module ccg_cam_model (
  output logic pixClk,
  output logic frameSync,
  output logic lineSync,
  output logic [7:0] pixBus
);
  initial {pixClk, frameSync, lineSync, pixBus} = 11'h0FF;  // Idle, clock still
  // Control lines are not modelled: an unpowered camera leaves them released
  // One frame of n bytes from base; clock runs only inside the frame
  // Pins move by non-blocking assignment, so a change on a ref_clk edge never races
  task automatic send(input logic [7:0] base, input int n);
    frameSync <= 1'b1;
    #100 lineSync <= 1'b1;
    for (int i = 0; i < n; i++) begin
      pixBus <= base + 8'(i);  // Data settles half a period before the edge
      #100 pixClk <= 1'b1;  // 200 ns period, inside the legal range
      #100 pixClk <= 1'b0;
    end
    pixBus <= ~pixBus;  // No stale byte after the line
    #100 lineSync <= 1'b0;
    #100 frameSync <= 1'b0;
    #400;
  endtask : send
endmodule : ccg_cam_model

//--- test_ccg_capture_top.sv
// Self-checking bench of the camera capture block
`timescale 1ns/1ps
`define CHK(nm, e, a) begin numChecks++; if ((a) !== (e)) begin errorCnt++; \
  $display("Error %s expected %h seen %h", nm, e, a); end end
module test_ccg_capture_top;
  logic ref_clk = 0, rst_n = 0, we_i = 0, cyc_i = 0, stb_i = 0, dmaReady = 0;
  logic [19:0] adr_i = 20'h00000;
  logic [31:0] dat_i = 32'h0000_0000, dat_o, dmaData, dispData, q;
  logic [3:0] sel_i = 4'h0, subClkEn;
  logic ack_o, cameraMasterClock, cameraResetOut_n, displayResetOut_n, cameraPowerOn;
  logic dmaValid, irq, dispValid, dispSeen = 1'b0;
  wire logic cameraPixelClockIn, frameSync, lineSync;
  wire logic [7:0] cameraPixelBus;
  int errorCnt = 0, numChecks = 0, cycCnt = 0, n;
  always #12.5 ref_clk = ~ref_clk;
  ccg_capture_top ccg_capture_top_i (.ref_clk, .rst_n, .adr_i, .dat_i, .dat_o, .we_i, .sel_i,
    .cyc_i, .stb_i, .ack_o, .cameraPixelClockIn, .frameSync, .lineSync, .cameraPixelBus,
    .cameraMasterClock, .cameraResetOut_n, .displayResetOut_n, .cameraPowerOn, .subClkEn,
    .subReset_n(), .dmaValid, .dmaData, .dmaReady, .dispValid, .dispData, .irq);
  ccg_cam_model ccg_cam_model_i (.pixClk(cameraPixelClockIn), .frameSync, .lineSync,
    .pixBus(cameraPixelBus));
  // Wishbone cycle; n counts rising edges until ack is sampled high
  task automatic wb(input logic w, input logic [19:0] a, input logic [31:0] d,
    input logic [3:0] s = 4'hF);
    @(posedge ref_clk) {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, s};
    n = 0;
    do begin @(posedge ref_clk); n++; end while (ack_o !== 1'b1);
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask : wb
  // Take one DMA word after checking it
  task automatic pop(input logic [31:0] e);
    @(negedge ref_clk) `CHK("dma", {1'b1, e}, {dmaValid, dmaData})
    @(posedge ref_clk) dmaReady <= 1'b1;
    @(posedge ref_clk) dmaReady <= 1'b0;
  endtask : pop
  task automatic t_regs;
    wb(0, 20'h00000, 0); `CHK("ctrl", 32'h0000_0006, q)
    wb(0, 20'h0000C, 0); `CHK("clkrst", 32'h0000_000F, q)
    wb(1, 20'h0000C, 32'h0000_070F); `CHK("wrlat", 2, n)
    repeat (2) @(negedge ref_clk);
    `CHK("outs", 3'h7, {cameraResetOut_n, displayResetOut_n, cameraPowerOn})
    `CHK("clken", 4'hF, subClkEn)
    $display("regs test done");
  endtask : t_regs
  task automatic t_mem;
    wb(1, 20'h40010, 32'hA5C3_1E77);
    wb(1, 20'h40010, 32'h0000_00FF, 4'h1);  // Byte lane write
    wb(0, 20'h40010, 0); `CHK("mem", 32'hA5C3_1E77 | 32'h0000_0088, q)
    `CHK("rdlat", 3, n)
    wb(0, 20'hC0000, 0); `CHK("unmap", 32'h0000_0000, q)
    $display("mem test done");
  endtask : t_mem
  task automatic t_dma;
    wb(1, 20'h00000, 32'h0000_040F);  // Capture to DMA, keep one frame then skip one
    for (int f = 0; f < 3; f++) ccg_cam_model_i.send(8'(16 * f), 4);
    pop(32'h0001_0203);
    pop(32'h2021_2223);
    @(negedge ref_clk) `CHK("empty", 1'b0, dmaValid)
    $display("dma test done");
  endtask : t_dma
  task automatic t_ovf;
    ccg_cam_model_i.send(8'hEE, 4);  // Skipped frame
    wb(1, 20'h00004, 32'h0000_000F);
    ccg_cam_model_i.send(8'h40, 24);  // Six words into a four-word queue
    wb(0, 20'h00004, 0); `CHK("stat", 32'h0000_000B, q)
    `CHK("irqoff", 1'b0, irq)
    wb(1, 20'h00008, 32'h0000_0008); repeat (2) @(negedge ref_clk);
    `CHK("irqon", 1'b1, irq)
    wb(1, 20'h00004, 32'h0000_000F); repeat (2) @(negedge ref_clk);
    `CHK("irqclr", 1'b0, irq)
    for (int i = 0; i < 4; i++) pop(32'h4041_4243 + 32'(i) * 32'h0404_0404);
    $display("overflow test done");
  endtask : t_ovf
  task automatic t_cap;
    // Memory route, area A, swap pairs, YUV to display, no skipping
    wb(1, 20'h00000, 32'h0000_0177);
    ccg_cam_model_i.send(8'hEE, 4);  // Skipped: skip count left over from the last frame
    ccg_cam_model_i.send(8'h10, 4);
    wb(0, 20'h50000, 0); `CHK("area", 32'h1110_1312, q)
    `CHK("disp", {1'b1, 32'h1110_1312}, {dispSeen, dispData})
    wb(0, 20'h00014, 0); `CHK("wrptr", 32'h0001_0004, q)
    wb(0, 20'h00010, 0); `CHK("lines", 32'h0000_0001, q)
    $display("capture test done");
  endtask : t_cap
  task automatic giveVerdict;
    $display("checks %0d errors %0d", numChecks, errorCnt);
    if (errorCnt == 0 && numChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : giveVerdict
  always @(posedge ref_clk) begin
    cycCnt++;
    if (dispValid === 1'b1) dispSeen <= 1'b1;
    if (cycCnt == 5000) begin errorCnt++; giveVerdict; end
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs; t_mem; t_dma; t_ovf; t_cap; giveVerdict;
  end
endmodule : test_ccg_capture_top
